// >>> hw/scer_pkg.sv
// Package for the sensor configuration and error register bank.
// Assumes a 250 MHz core clock and a byte-wide register port.
package scer_pkg;

  // Register offsets, byte addresses of the register port
  localparam logic [7:0] ADDR_FAULT_FLAGS  = 8'h5F;
  localparam logic [7:0] ADDR_NVM_MODE     = 8'h6A;
  localparam logic [7:0] ADDR_PORT_SET     = 8'h6B;
  localparam logic [7:0] ADDR_SELF_CHECK   = 8'h6D;
  localparam logic [7:0] ADDR_PERSIST_CFG  = 8'h70;
  localparam logic [7:0] ADDR_X_TRIM       = 8'h71;
  localparam logic [7:0] ADDR_COMMAND      = 8'h7E;

  // Reset values
  localparam logic [7:0] RST_BYTE          = 8'h00;

  // Command codes
  localparam logic [7:0] CMD_NVM_PROGRAM   = 8'hA0;

  // Field positions
  localparam int FAULT_LONG_BIT    = 1;
  localparam int FAULT_FATAL_BIT   = 2;
  localparam int NVM_PROG_EN_BIT   = 1;
  localparam int THREE_WIRE_BIT    = 0;
  localparam int AUX_MODE_BIT      = 4;
  localparam int ST_EN_BIT         = 0;
  localparam int ST_SIGN_BIT       = 2;
  localparam int ST_AMP_BIT        = 3;
  localparam int SPI_EN_BIT        = 0;
  localparam int WDT_SEL_BIT       = 1;
  localparam int WDT_EN_BIT        = 2;
  localparam int OFF_EN_BIT        = 3;

  // Writable masks; reserved bits stay zero
  localparam logic [7:0] MASK_NVM_MODE     = 8'h02;
  localparam logic [7:0] MASK_PORT_SET     = 8'h11;
  localparam logic [7:0] MASK_SELF_CHECK   = 8'h0D;
  localparam logic [7:0] MASK_PERSIST_CFG  = 8'h0F;
  localparam logic [7:0] MASK_X_TRIM       = 8'hFF;

  // Non-volatile slots
  localparam int NVM_WORDS         = 2;
  localparam logic [0:0] NVM_SLOT_CFG  = 1'h0;
  localparam logic [0:0] NVM_SLOT_TRIM = 1'h1;

  // Watchdog timing
  localparam int CLK_PERIOD_PS     = 4000;
  localparam longint WDT_SHORT_PS  = 64'd1250000000;   // 1.25 ms
  localparam longint WDT_LONG_PS   = 64'd40000000000;  // 40 ms
  localparam int WDT_SHORT_CYC     = int'(WDT_SHORT_PS / CLK_PERIOD_PS);
  localparam int WDT_LONG_CYC      = int'(WDT_LONG_PS / CLK_PERIOD_PS);
  localparam int WDT_CNT_W         = 24;

  // Acceleration sample width
  localparam int ACC_W             = 16;

endpackage

// >>> hw/scer_regs.sv
// Configuration and error register bank of a triaxial acceleration sensor.
// Assumes a byte register port driven by the serial front end on CLK_I,
// error events from the processing core, and the serial data pin raw.
`timescale 1ns/1ps

// Behaviour
// - Long-processing event sets fault bit 1 and halts processing.
// - Fatal-error event sets fault bit 2 and halts processing.
// - Bit 1 of controller mode permits the program command when set.
// - Bit 0 of port settings selects three-wire SPI when set.
// - Bit 4 of port settings turns auxiliary magnetometer port on.
// - Bit 0 of self-check control enables self-test.
// - Bit 2 of self-check control picks positive excitation when set.
// - Bit 3 of self-check control picks high amplitude when set.
// - Persistent configuration is backed by non-volatile storage, stored and restored.
// - Bit 0 of persistent config disables I2C and enables SPI in autoconfig.
// - Bit 1 of persistent config picks long 40 ms watchdog, else 1.25 ms.
// - Bit 2 of persistent config enables I2C watchdog on data pin.
// - Bit 3 of persistent config adds axis offset to acceleration data.
// - Eight-bit X trim, read-write, non-volatile backed, resets to zero.
// - Program command copies all backed registers into non-volatile storage.
module scer_regs
  import scer_pkg::*;
#(
  parameter int WDT_SHORT_CYCLES = WDT_SHORT_CYC,
  parameter int WDT_LONG_CYCLES  = WDT_LONG_CYC
) (
  input  wire logic             CLK_I,
  input  wire logic             RSTN_I,
  input  wire logic [7:0]       ADDR_I,
  input  wire logic [7:0]       WDATA_I,
  input  wire logic             WR_I,
  input  wire logic             RD_I,
  output logic      [7:0]       RDATA_O,
  output logic                  RVALID_O,
  input  wire logic             ERR_LONG_I,
  input  wire logic             ERR_FATAL_I,
  output logic                  HALT_O,
  input  wire logic             NVM_RESTORE_I,
  output logic                  NVM_PROG_DONE_O,
  output logic                  THREE_WIRE_O,
  output logic                  AUX_MAG_O,
  output logic                  SELF_TEST_EN_O,
  output logic                  SELF_TEST_POS_O,
  output logic                  SELF_TEST_HIGH_O,
  output logic                  SPI_EN_O,
  input  wire logic             SERIAL_DATA_IN_PIN_I,
  output logic                  WDT_TIMEOUT_O,
  input  wire logic [ACC_W-1:0] ACC_X_I,
  input  wire logic             ACC_X_VALID_I,
  output logic      [ACC_W-1:0] ACC_X_O,
  output logic                  ACC_X_VALID_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [7:0]       fault_flags_r;
  logic [7:0]       nonvolatile_controller_mode_r;
  logic [7:0]       serial_port_settings_r;
  logic [7:0]       self_check_control_r;
  logic [7:0]       persistent_config_bits_r;
  logic [7:0]       x_axis_trim_r;
  logic [7:0]       nvm_mem [NVM_WORDS];
  logic             sdi_meta_r;
  logic             sdi_sync_r;
  logic [WDT_CNT_W-1:0] wdt_cnt_r;
  logic [WDT_CNT_W-1:0] wdt_limit;
  logic             wdt_armed;
  logic             prog_cmd;
  logic [ACC_W-1:0] trim_ext;

  // Command write decode; the command register itself is never stored
  assign prog_cmd = WR_I && (ADDR_I == ADDR_COMMAND) && (WDATA_I == CMD_NVM_PROGRAM);

  ////////////////////////////////////////////////////////////////////////////
  // Fault flags: sticky until reset, set by the core's events

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      fault_flags_r <= RST_BYTE;
    end else begin
      if (ERR_LONG_I) begin
        fault_flags_r[FAULT_LONG_BIT] <= 1'b1;
      end
      if (ERR_FATAL_I) begin
        fault_flags_r[FAULT_FATAL_BIT] <= 1'b1;
      end
    end
  end

  // Halt also decodes the raw events, so it rises with the flag, one cycle after the event
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      HALT_O <= 1'b0;
    end else begin
      HALT_O <= ERR_LONG_I || ERR_FATAL_I || fault_flags_r[FAULT_LONG_BIT] || fault_flags_r[FAULT_FATAL_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Volatile control registers; reserved bits are masked so they read zero

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      nonvolatile_controller_mode_r <= RST_BYTE;
    end else if (WR_I && (ADDR_I == ADDR_NVM_MODE)) begin
      nonvolatile_controller_mode_r <= WDATA_I & MASK_NVM_MODE;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      serial_port_settings_r <= RST_BYTE;
    end else if (WR_I && (ADDR_I == ADDR_PORT_SET)) begin
      serial_port_settings_r <= WDATA_I & MASK_PORT_SET;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      self_check_control_r <= RST_BYTE;
    end else if (WR_I && (ADDR_I == ADDR_SELF_CHECK)) begin
      self_check_control_r <= WDATA_I & MASK_SELF_CHECK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Non-volatile backed registers; a restore has priority over a host write
  // so the stored image is never half overwritten by a racing host access.
  // Restoring before the first program loads unknown cells; software must
  // program once before it relies on a restore.

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      persistent_config_bits_r <= RST_BYTE;
    end else if (NVM_RESTORE_I) begin
      persistent_config_bits_r <= nvm_mem[NVM_SLOT_CFG] & MASK_PERSIST_CFG;
    end else if (WR_I && (ADDR_I == ADDR_PERSIST_CFG)) begin
      persistent_config_bits_r <= WDATA_I & MASK_PERSIST_CFG;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      x_axis_trim_r <= RST_BYTE;
    end else if (NVM_RESTORE_I) begin
      x_axis_trim_r <= nvm_mem[NVM_SLOT_TRIM];
    end else if (WR_I && (ADDR_I == ADDR_X_TRIM)) begin
      x_axis_trim_r <= WDATA_I & MASK_X_TRIM;
    end
  end

  // Storage array has no reset: it models cells that survive power loss
  always_ff @(posedge CLK_I) begin
    if (prog_cmd && nonvolatile_controller_mode_r[NVM_PROG_EN_BIT]) begin
      nvm_mem[NVM_SLOT_CFG]  <= persistent_config_bits_r;
      nvm_mem[NVM_SLOT_TRIM] <= x_axis_trim_r;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      NVM_PROG_DONE_O <= 1'b0;
    end else begin
      NVM_PROG_DONE_O <= prog_cmd && nonvolatile_controller_mode_r[NVM_PROG_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port: one cycle latency, reserved bits and unmapped offsets read zero

  // Valid strobe follows the read strobe by one cycle
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      RVALID_O <= 1'b0;
    end else begin
      RVALID_O <= RD_I;
    end
  end

  // Data holds until the next read, so a slow host may sample late
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      RDATA_O <= RST_BYTE;
    end else begin
      if (RD_I) begin
        unique case (ADDR_I)
          ADDR_FAULT_FLAGS: RDATA_O <= fault_flags_r;
          ADDR_NVM_MODE:    RDATA_O <= nonvolatile_controller_mode_r;
          ADDR_PORT_SET:    RDATA_O <= serial_port_settings_r;
          ADDR_SELF_CHECK:  RDATA_O <= self_check_control_r;
          ADDR_PERSIST_CFG: RDATA_O <= persistent_config_bits_r;
          ADDR_X_TRIM:      RDATA_O <= x_axis_trim_r;
          default:          RDATA_O <= RST_BYTE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs, registered copies of the fields; the extra cycle keeps
  // every top-level output straight from a flop

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      THREE_WIRE_O <= 1'b0;
    end else begin
      THREE_WIRE_O <= serial_port_settings_r[THREE_WIRE_BIT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      AUX_MAG_O <= 1'b0;
    end else begin
      AUX_MAG_O <= serial_port_settings_r[AUX_MODE_BIT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      SELF_TEST_EN_O <= 1'b0;
    end else begin
      SELF_TEST_EN_O <= self_check_control_r[ST_EN_BIT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      SELF_TEST_POS_O <= 1'b0;
    end else begin
      SELF_TEST_POS_O <= self_check_control_r[ST_SIGN_BIT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      SELF_TEST_HIGH_O <= 1'b0;
    end else begin
      SELF_TEST_HIGH_O <= self_check_control_r[ST_AMP_BIT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      SPI_EN_O <= 1'b0;
    end else begin
      SPI_EN_O <= persistent_config_bits_r[SPI_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // I2C watchdog: a data pin held low too long raises a timeout pulse on WDT_TIMEOUT_O

  // Pin is asynchronous, so two flops before anything looks at it
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      sdi_meta_r <= 1'b1;
      sdi_sync_r <= 1'b1;
    end else begin
      sdi_meta_r <= SERIAL_DATA_IN_PIN_I;
      sdi_sync_r <= sdi_meta_r;
    end
  end

  assign wdt_limit = persistent_config_bits_r[WDT_SEL_BIT] ? WDT_CNT_W'(WDT_LONG_CYCLES) :
                                                             WDT_CNT_W'(WDT_SHORT_CYCLES);
  // only in I2C mode with enable
  assign wdt_armed = persistent_config_bits_r[WDT_EN_BIT] && !persistent_config_bits_r[SPI_EN_BIT];

  // Counter of cycles with the synced pin low; a high pin or disarm clears it
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      wdt_cnt_r <= '0;
    end else begin
      if (!wdt_armed || sdi_sync_r) begin
        wdt_cnt_r <= '0;
      end else if (wdt_cnt_r == wdt_limit - 1'b1) begin
        // Restart counting, so a pin stuck low gives a pulse per period
        wdt_cnt_r <= '0;
      end else begin
        wdt_cnt_r <= wdt_cnt_r + 1'b1;
      end
    end
  end

  // one-cycle timeout pulse at the wrap of the counter
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      WDT_TIMEOUT_O <= 1'b0;
    end else begin
      WDT_TIMEOUT_O <= wdt_armed && !sdi_sync_r && (wdt_cnt_r == wdt_limit - 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset path: trim is signed, one LSB per data LSB, wraps on overflow

  assign trim_ext = {{(ACC_W-8){x_axis_trim_r[7]}}, x_axis_trim_r};

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      ACC_X_O       <= '0;
      ACC_X_VALID_O <= 1'b0;
    end else begin
      ACC_X_VALID_O <= ACC_X_VALID_I;
      if (ACC_X_VALID_I) begin
        ACC_X_O <= persistent_config_bits_r[OFF_EN_BIT] ? ACC_X_I + trim_ext : ACC_X_I;
      end
    end
  end

endmodule // scer_regs

// >>> test/scer_host.sv
// Host model on the byte register port.
// Assumes the bank answers a read one cycle after the strobe.
`timescale 1ns/1ps
module scer_host
  import scer_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  // Idle bus at time zero
  initial begin
    addr_o = 8'h00; wdata_o = 8'h00; wr_o = 1'b0; rd_o = 1'b0;
  end
  // Single write, strobe held one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a; wdata_o <= d; wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  // Single read; bounded wait so a dead port cannot hang the run
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    @(posedge clk_i);
    addr_o <= a; rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    ok = 0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1 ok = (rvalid_i === 1'b1);
      d = rdata_i;
      if (!ok) @(posedge clk_i);
    end
    if (a == ADDR_FAULT_FLAGS) d = d & 8'h06;
  endtask
endmodule // scer_host

// >>> test/scer_regs_bench.sv
// Self-checking bench for the register bank.
// Assumes the host model drives the register port; short watchdog limits.
`timescale 1ns/1ps
module scer_regs_bench;
  import scer_pkg::*;
  localparam int SHORT = 8;
  localparam int LONG  = 20;
  logic        clk = 0, rstn = 0, e_long = 0, e_fatal = 0, restore = 0, pin = 1, av = 0;
  logic [15:0] ax = 16'h0000, axo;
  logic [7:0]  addr, wd, rdata;
  logic        wr, rd, rv, halt, done, tw, aux, sten, stp, sth, spi, wdt, avo;
  int          mismatches = 0, num_checks = 0, n;
  logic [7:0]  adr [8] = '{8'h5F, 8'h6A, 8'h6B, 8'h6D, 8'h70, 8'h71, 8'h3C, 8'h7E};
  logic [7:0]  msk [8] = '{8'h00, 8'h02, 8'h11, 8'h0D, 8'h0F, 8'hFF, 8'h00, 8'h00};

  always #2 clk = ~clk;

  scer_host i_host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rv), .addr_o(addr), .wdata_o(wd), .wr_o(wr), .rd_o(rd));
  scer_regs #(.WDT_SHORT_CYCLES(SHORT), .WDT_LONG_CYCLES(LONG)) i_dut (
    .CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .RVALID_O(rv), .ERR_LONG_I(e_long), .ERR_FATAL_I(e_fatal), .HALT_O(halt), .NVM_RESTORE_I(restore),
    .NVM_PROG_DONE_O(done), .THREE_WIRE_O(tw), .AUX_MAG_O(aux), .SELF_TEST_EN_O(sten), .SELF_TEST_POS_O(stp),
    .SELF_TEST_HIGH_O(sth), .SPI_EN_O(spi), .SERIAL_DATA_IN_PIN_I(pin), .WDT_TIMEOUT_O(wdt), .ACC_X_I(ax),
    .ACC_X_VALID_I(av), .ACC_X_O(axo), .ACC_X_VALID_O(avo));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    bit ok;
    i_host.rd(a, d, ok);
    if (!ok) mismatches++;
    chk({8'h00, d}, {8'h00, e});
  endtask
  // Program command; done pulse is looked for over three edges
  task automatic prog(input logic e);
    logic seen;
    seen = 0;
    i_host.wr(ADDR_COMMAND, CMD_NVM_PROGRAM);
    repeat (3) begin
      #1 seen = seen | done;
      @(posedge clk);
    end
    chk(16'(seen), 16'(e));
  endtask
  task automatic acc(input logic [15:0] e);
    @(posedge clk) begin ax <= 16'h1234; av <= 1; end
    @(posedge clk) av <= 0;
    #1 chk(16'(avo), 16'h0001);
    chk(axo, e);
  endtask
  // Pin held low; cycles to the timeout pulse, capped at 60
  task automatic wdt_wait(input logic [7:0] cfg, input int lo, input int hi);
    i_host.wr(ADDR_PERSIST_CFG, cfg);
    @(posedge clk) pin <= 0;
    n = 0;
    while (wdt !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1 n++;
    end
    chk(16'(n >= lo && n <= hi), 16'h0001);
    @(posedge clk) pin <= 1;
    repeat (4) @(posedge clk);
  endtask
  task give_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict;
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    foreach (adr[i]) rchk(adr[i], 8'h00);
    $display("test reset done");
    for (int v = 255; v >= 0; v -= 255) begin
      foreach (adr[i]) i_host.wr(adr[i], 8'(v));
      foreach (adr[i]) rchk(adr[i], msk[i] & 8'(v));
      #1 chk(16'({tw, aux, sten, stp, sth, spi}), 16'(v[0] ? 6'h3F : 6'h00));
    end
    $display("test fields done");
    i_host.wr(ADDR_PERSIST_CFG, 8'h0B);
    i_host.wr(ADDR_X_TRIM, 8'hFF);
    prog(1'b0);
    i_host.wr(ADDR_NVM_MODE, 8'h02);
    prog(1'b1);
    i_host.wr(ADDR_PERSIST_CFG, 8'h00);
    i_host.wr(ADDR_X_TRIM, 8'h00);
    @(posedge clk) restore <= 1;
    @(posedge clk) restore <= 0;
    rchk(ADDR_PERSIST_CFG, 8'h0B);
    rchk(ADDR_X_TRIM, 8'hFF);
    $display("test storage done");
    acc(16'h1233);
    i_host.wr(ADDR_PERSIST_CFG, 8'h00);
    acc(16'h1234);
    $display("test offset done");
    wdt_wait(8'h04, SHORT, SHORT + 4);
    wdt_wait(8'h06, LONG, LONG + 4);
    wdt_wait(8'h00, 60, 60);
    $display("test watchdog done");
    chk(16'(halt), 16'h0000);
    @(posedge clk) e_long <= 1;
    @(posedge clk) e_long <= 0;
    #1 chk(16'(halt), 16'h0001);
    rchk(ADDR_FAULT_FLAGS, 8'h02);
    @(posedge clk) e_fatal <= 1;
    @(posedge clk) e_fatal <= 0;
    rchk(ADDR_FAULT_FLAGS, 8'h06);
    $display("test faults done");
    give_verdict;
  end
endmodule // scer_regs_bench

// >>> test/scer_regs_properties.sv
// Port checker for the register bank.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module scer_regs_chk
  import scer_pkg::*;
#(
  parameter int WDT_SHORT_CYCLES = 8,
  parameter int WDT_LONG_CYCLES  = 20
) (
  input wire logic       CLK_I, RSTN_I, WR_I, RD_I, RVALID_O, ERR_LONG_I, ERR_FATAL_I, HALT_O,
  input wire logic       NVM_PROG_DONE_O, THREE_WIRE_O, AUX_MAG_O, SELF_TEST_EN_O, SELF_TEST_POS_O,
  input wire logic       SELF_TEST_HIGH_O, SPI_EN_O, WDT_TIMEOUT_O, ACC_X_VALID_I, ACC_X_VALID_O,
  input wire logic [7:0] ADDR_I, WDATA_I
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  a_halt_long: assert property (ERR_LONG_I |=> HALT_O)
    else $error("halt missing after long event");
  a_halt_fatal: assert property (ERR_FATAL_I |=> HALT_O)
    else $error("halt missing after fatal event");
  a_halt_stays: assert property (HALT_O |=> HALT_O)
    else $error("halt dropped");
  a_read_answer: assert property (RD_I |=> RVALID_O)
    else $error("read not answered");
  a_wire_mode: assert property (WR_I && ADDR_I == ADDR_PORT_SET |-> ##2 THREE_WIRE_O == $past(WDATA_I[0], 2))
    else $error("three wire output wrong");
  a_aux_mode: assert property (WR_I && ADDR_I == ADDR_PORT_SET |-> ##2 AUX_MAG_O == $past(WDATA_I[4], 2))
    else $error("aux output wrong");
  a_self_test: assert property (WR_I && ADDR_I == ADDR_SELF_CHECK |-> ##2
    {SELF_TEST_HIGH_O, SELF_TEST_POS_O, SELF_TEST_EN_O} == {$past(WDATA_I[3:2], 2), $past(WDATA_I[0], 2)})
    else $error("self test outputs wrong");
  a_spi_select: assert property (WR_I && ADDR_I == ADDR_PERSIST_CFG |-> ##2 SPI_EN_O == $past(WDATA_I[0], 2))
    else $error("spi enable wrong");
  a_prog_cause: assert property (NVM_PROG_DONE_O |-> $past(WR_I && ADDR_I == ADDR_COMMAND))
    else $error("program done without command");
  a_acc_latency: assert property (ACC_X_VALID_I |=> ACC_X_VALID_O)
    else $error("sample valid late");
  a_wdt_pulse: assert property (WDT_TIMEOUT_O |=> !WDT_TIMEOUT_O)
    else $error("watchdog pulse too long");
  c_prog: cover property (NVM_PROG_DONE_O);
  c_wdt: cover property (WDT_TIMEOUT_O);
  c_halt: cover property ($rose(HALT_O));
endmodule // scer_regs_chk

bind scer_regs scer_regs_chk #(.WDT_SHORT_CYCLES(WDT_SHORT_CYCLES), .WDT_LONG_CYCLES(WDT_LONG_CYCLES)) i_chk (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .WR_I(WR_I), .RD_I(RD_I), .RVALID_O(RVALID_O), .ERR_LONG_I(ERR_LONG_I),
  .ERR_FATAL_I(ERR_FATAL_I), .HALT_O(HALT_O), .NVM_PROG_DONE_O(NVM_PROG_DONE_O), .THREE_WIRE_O(THREE_WIRE_O),
  .AUX_MAG_O(AUX_MAG_O), .SELF_TEST_EN_O(SELF_TEST_EN_O), .SELF_TEST_POS_O(SELF_TEST_POS_O),
  .SELF_TEST_HIGH_O(SELF_TEST_HIGH_O), .SPI_EN_O(SPI_EN_O), .WDT_TIMEOUT_O(WDT_TIMEOUT_O),
  .ACC_X_VALID_I(ACC_X_VALID_I), .ACC_X_VALID_O(ACC_X_VALID_O), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I));
